/* File: shbc_top.sv */
/*
 Serial control block of a six half-bridge driver: command word in,
 status word out, switch drive, enables and short-circuit timing.
 Assumes the serial pins and hardware enable are asynchronous inputs
 and status flags come from analog sensing as levels.
*/
// Functional notes
// - A frame starts when chip select falls.
// - The shifted command takes effect only on chip select rising.
// - Serial input is sampled on the falling serial clock edge.
// - Serial output is driven once chip select falls.
// - Serial output changes on rising clock edges and when chip select falls.
// - Serial output is high impedance while chip select is high.
// - Status word goes out least significant bit first.
// - Reset request clears supply fail, short detected and thermal latch.
// - Bits 1 to 12 switch low and high sides, high means on.
// - Bit 13 low enables open-load detection.
// - Bit 14 high gives 12 ms short delay, low 1.5 ms.
// - Bit 15 low is software standby.
// - Serial interface keeps working in standby.
// - Hardware enable low is standby.
// - Fault pin pulled low on over-temperature or over-current.
// - Status bits: prewarn, switch states (open-load flags when bit 13 low), short, enable, supply fail.
// - After thermal shutdown every status bit reads high.
// - Outputs run only when both enables are high.
// - Reset request clears short flag and re-enables shorted outputs.
`timescale 1ns/1ns
`default_nettype none
module shbc_top
   import shbc_pkg::*;
(
   // System
   input  wire logic                  mclk_i,
   input  wire logic                  nrst_i,
   // Serial pins
   input  wire logic                  cs_n_i,
   input  wire logic                  sclk_i,
   input  wire logic                  serial_in_i,
   output logic                       serial_out_o,
   output logic                       serial_out_oe_o,
   // Hardware enable pin
   input  wire logic                  hw_enable_i,
   // Sensing flags
   input  wire logic                  temp_prewarn_i,
   input  wire logic                  over_temp_i,
   input  wire logic                  supply_low_i,
   input  wire logic [2*NUM_BR-1:0]   over_current_i,
   input  wire logic [2*NUM_BR-1:0]   open_load_i,
   // Power stage controls
   output logic [2*NUM_BR-1:0]        switch_on_o,
   output logic                       open_load_en_o,
   output logic                       enable_o,
   output logic                       error_indicator_n_o,
   output logic                       error_indicator_n_oe_o
);
   import shbc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [1:0] cs_s, ck_s, di_s, en_s;
   logic       cs_d, ck_d;
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cs_s <= 2'h3;
         ck_s <= 2'h0;
         di_s <= 2'h0;
         en_s <= 2'h0;
         cs_d <= 1'b1;
         ck_d <= 1'b0;
      end else begin
         cs_s <= {cs_s[0], cs_n_i};
         ck_s <= {ck_s[0], sclk_i};
         di_s <= {di_s[0], serial_in_i};
         en_s <= {en_s[0], hw_enable_i};
         cs_d <= cs_s[1];
         ck_d <= ck_s[1];
      end
   end

   shbc_ser_if ser ();
   assign ser.frame_start = cs_d && !cs_s[1];
   assign ser.frame_end   = !cs_d && cs_s[1];
   assign ser.clk_rise    = !cs_s[1] && !ck_d && ck_s[1];
   assign ser.clk_fall    = !cs_s[1] && ck_d && !ck_s[1];
   assign ser.din         = di_s[1];

   shbc_shifter u_shf (
      .mclk_i (mclk_i),
      .nrst_i (nrst_i),
      .ser    (ser)
   );

   ////////////////////////////////////////////////////////////////////////
   // Command register, applied on chip select rising
   logic [WORD_W-1:0] cmd;
   logic              srr_pulse;
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cmd       <= CMD_RESET;
         srr_pulse <= 1'b0;
      end else begin
         srr_pulse <= 1'b0;
         if (ser.frame_end) begin
            cmd       <= ser.cmd_word;
            srr_pulse <= ser.cmd_word[CMD_SRR_BIT];
         end
      end
   end

   logic eff_en;
   assign eff_en = cmd[CMD_SE_BIT] && en_s[1];

   ////////////////////////////////////////////////////////////////////////
   // Short-circuit timers and latched flags
   logic [2*NUM_BR-1:0] sc_off;
   logic [SC_CNT_W-1:0] sc_cnt [2*NUM_BR];
   logic [SC_CNT_W-1:0] sc_limit;
   logic                ot_latch, psf_latch;
   assign sc_limit = cmd[CMD_SCT_BIT] ? SC_CNT_W'(SC_LONG_CYC)
                                      : SC_CNT_W'(SC_SHORT_CYC);

   genvar g;
   generate
      for (g = 0; g < 2*NUM_BR; g++) begin : g_sc
         always_ff @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               sc_cnt[g] <= '0;
               sc_off[g] <= 1'b0;
            end else begin
               if (over_current_i[g] && switch_on_o[g]) begin
                  sc_cnt[g] <= (sc_cnt[g] >= sc_limit) ? sc_cnt[g]
                                                       : sc_cnt[g] + 1'b1;
               end else begin
                  sc_cnt[g] <= '0;
               end
               // A new trip wins over a reset request
               if (switch_on_o[g] && sc_cnt[g] >= sc_limit) begin
                  sc_off[g] <= 1'b1;
               end else if (srr_pulse) begin
                  sc_off[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ot_latch  <= 1'b0;
         psf_latch <= 1'b0;
      end else begin
         if (over_temp_i) begin
            ot_latch <= 1'b1;
         end else if (srr_pulse) begin
            ot_latch <= 1'b0;
         end
         if (supply_low_i) begin
            psf_latch <= 1'b1;
         end else if (srr_pulse) begin
            psf_latch <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power stage drive
   logic [2*NUM_BR-1:0] sw_cmd;
   assign sw_cmd = cmd[CMD_SW_LO +: 2*NUM_BR];
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         switch_on_o    <= '0;
         open_load_en_o <= 1'b0;
         enable_o       <= 1'b0;
      end else begin
         switch_on_o    <= (eff_en && !ot_latch) ? (sw_cmd & ~sc_off) : '0;
         open_load_en_o <= !cmd[CMD_OLD_BIT];
         enable_o       <= eff_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status word
   logic [2*NUM_BR-1:0] sw_stat;
   assign sw_stat = cmd[CMD_OLD_BIT] ? switch_on_o : open_load_i;
   always_comb begin
      ser.status_word = {psf_latch, eff_en, |sc_off, sw_stat, temp_prewarn_i};
      if (ot_latch) begin
         ser.status_word = ALL_ONES;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial output and fault pin
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         serial_out_o           <= 1'b0;
         serial_out_oe_o        <= 1'b0;
         error_indicator_n_o    <= 1'b0;
         error_indicator_n_oe_o <= 1'b0;
      end else begin
         serial_out_o           <= ser.dout;
         serial_out_oe_o        <= !cs_s[1];
         error_indicator_n_o    <= 1'b0;
         error_indicator_n_oe_o <= ot_latch || (|sc_off);
      end
   end
endmodule
`default_nettype wire

/* File: shbc_pkg.sv */
/*
 Constants for the serial half-bridge control block: command and status
 field positions, reset values and short-circuit delay counts.
 Assumes a 100 MHz system clock.
*/
package shbc_pkg;
   localparam int          WORD_W        = 16;
   localparam int          NUM_BR        = 6;
   localparam int          CLK_NS        = 10;
   // Command word fields
   localparam int          CMD_SRR_BIT   = 0;
   localparam int          CMD_SW_LO     = 1;
   localparam int          CMD_OLD_BIT   = 13;
   localparam int          CMD_SCT_BIT   = 14;
   localparam int          CMD_SE_BIT    = 15;
   // Status word fields
   localparam int          ST_TP_BIT     = 0;
   localparam int          ST_SCD_BIT    = 13;
   localparam int          ST_EN_BIT     = 14;
   localparam int          ST_PSF_BIT    = 15;
   // Command word after reset: SE, SHORT_TIMER_SELECT, OLD high, all switches off
   localparam logic [15:0] CMD_RESET     = 16'hE000;
   localparam logic [15:0] ALL_ONES      = 16'hFFFF;
   // Short-circuit shutdown delays
   localparam int          SC_LONG_US    = 12000;
   localparam int          SC_SHORT_US   = 1500;
   localparam int          SC_LONG_CYC   = SC_LONG_US * 1000 / CLK_NS;
   localparam int          SC_SHORT_CYC  = SC_SHORT_US * 1000 / CLK_NS;
   localparam int          SC_CNT_W      = 21;
endpackage

/* File: shbc_ser_if.sv */
/*
 Interface carrying the synchronised serial link between the top module
 and its shifter. Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface shbc_ser_if;
   logic        frame_start;
   logic        frame_end;
   logic        clk_rise;
   logic        clk_fall;
   logic        din;
   logic [15:0] status_word;
   logic [15:0] cmd_word;
   logic        dout;
   modport top (output frame_start, frame_end, clk_rise, clk_fall, din, status_word,
                input cmd_word, dout);
   modport shf (input frame_start, frame_end, clk_rise, clk_fall, din, status_word,
                output cmd_word, dout);
endinterface
`default_nettype wire

/* File: shbc_shifter.sv */
/*
 Serial shifter: shifts command bits in and status bits out, both
 least significant bit first. Assumes edge pulses from the top module.
*/
`timescale 1ns/1ns
`default_nettype none
module shbc_shifter
   import shbc_pkg::*;
(
   // System
   input  wire logic mclk_i,
   input  wire logic nrst_i,
   // Link
   shbc_ser_if.shf   ser
);
   logic [WORD_W-1:0] rx_sr;
   logic [WORD_W-1:0] tx_sr;

   // Last sixteen bits in the frame form the command word
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_sr <= '0;
      end else if (ser.clk_fall) begin
         rx_sr <= {ser.din, rx_sr[WORD_W-1:1]};
      end
   end
   assign ser.cmd_word = rx_sr;

   // Status loaded at frame start, bit 0 first; next bit on each rising clock
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tx_sr <= '0;
      end else if (ser.frame_start) begin
         tx_sr <= ser.status_word;
      end else if (ser.clk_rise) begin
         tx_sr <= {1'b0, tx_sr[WORD_W-1:1]};
      end
   end
   assign ser.dout = tx_sr[0];
endmodule
`default_nettype wire

/* File: shbc_top_sva_sva.sv */
/* Pin assertions for shbc_top.
   Assumes enables and faults hold still while chip select is low. */
`timescale 1ns/1ns
`default_nettype none
module shbc_top_sva (
   // Watched pins
   input wire logic        mclk_i,
   input wire logic        nrst_i,
   input wire logic        cs_n_i,
   input wire logic        sclk_i,
   input wire logic        serial_out_o,
   input wire logic        serial_out_oe_o,
   input wire logic        hw_enable_i,
   input wire logic        over_temp_i,
   input wire logic [11:0] switch_on_o,
   input wire logic        enable_o,
   input wire logic        error_indicator_n_o,
   input wire logic        error_indicator_n_oe_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   sequence idle_s; cs_n_i [*7]; endsequence
   sequence quiet_s; (!cs_n_i && !sclk_i) [*8]; endsequence
   a_dout_on: assert property ($fell(cs_n_i) |-> ##[2:6] serial_out_oe_o)
      else $error("dout not enabled");
   a_dout_off: assert property ($rose(cs_n_i) |-> ##[2:6] !serial_out_oe_o)
      else $error("dout not released");
   a_dout_idle: assert property (idle_s |-> !serial_out_oe_o)
      else $error("dout driven while idle");
   a_dout_hold: assert property (quiet_s |-> $stable(serial_out_o))
      else $error("dout moved without clock rise");
   a_cmd_hold: assert property (!cs_n_i [*8] |-> $stable(switch_on_o))
      else $error("switches moved inside frame");
   a_hw_off: assert property (!hw_enable_i [*8] |-> !enable_o && !switch_on_o)
      else $error("outputs live in standby");
   a_fault_on: assert property ($rose(over_temp_i) |-> ##[1:5] error_indicator_n_oe_o)
      else $error("fault pin not pulled");
   a_fault_low: assert property (error_indicator_n_oe_o |-> !error_indicator_n_o)
      else $error("fault pin drives high");
endmodule
bind shbc_top shbc_top_sva u_sva (.mclk_i, .nrst_i, .cs_n_i, .sclk_i, .serial_out_o,
   .serial_out_oe_o, .hw_enable_i, .over_temp_i, .switch_on_o, .enable_o,
   .error_indicator_n_o, .error_indicator_n_oe_o);
`default_nettype wire

/* File: shbc_host.sv */
/* Serial host model: command out, status in, both LSB first.
   Assumes mclk_i only for alignment; the link clock has an 80 ns period. */
`timescale 1ns/1ns
`default_nettype none
module shbc_host (
   // Clock
   input  wire logic   mclk_i,
   // Serial pins
   output logic        cs_n_o,
   output logic        sclk_o,
   output logic        serial_in_o,
   input  wire logic   serial_out_i,
   input  wire logic   serial_out_oe_i,
   // Result
   output logic [15:0] status_o,
   output logic        done_o
);
   // A released data line reads back inverted, never as the last bit
   wire logic dout_w = serial_out_oe_i ? serial_out_i : ~serial_out_i;
   initial {cs_n_o, sclk_o, serial_in_o, done_o} = 4'b1000;
   task automatic xfer(input logic [15:0] pre, input logic [15:0] cmd, input bit ch);
      logic [31:0] w;
      w = {cmd, pre};
      @(posedge mclk_i);
      #3 cs_n_o = 1'b0;
      #160;
      for (int i = ch ? 0 : 16; i < 32; i++) begin
         if (!ch || i < 16) status_o[i[3:0]] = dout_w;
         serial_in_o = w[i];
         sclk_o = 1'b1;
         #40 sclk_o = 1'b0;
         #40;
      end
      #120 cs_n_o = 1'b1;
      serial_in_o = 1'b0;
      done_o = 1'b1;
      #10 done_o = 1'b0;
      #200;
   endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
/* Self-checking bench for shbc_top driven by the serial host model.
   Assumes shbc_pkg and shbc_host are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, a); end end
module testbench;
   import shbc_pkg::*;
   typedef struct {logic [15:0] st; logic [11:0] sw; logic en; logic ol; logic ft;} shbc_note_t;
   logic        mclk_i, nrst_i, hw_enable_i, temp_prewarn_i, over_temp_i, supply_low_i;
   logic [11:0] over_current_i, open_load_i, switch_on_o;
   logic        cs_n, sclk, sin, sout, oe, open_load_en_o, enable_o, err_n, err_oe, done;
   logic [15:0] st_seen, cur;
   logic [31:0] seed = 32'h0000001F;
   logic [31:0] r;
   logic        supply_fail, ot;
   int          miscompares, checks_done;
   shbc_note_t  q[$];
   shbc_note_t  nt, mn;
   always #5 mclk_i = ~mclk_i;
   shbc_top i_dut (.mclk_i, .nrst_i, .cs_n_i(cs_n), .sclk_i(sclk), .serial_in_i(sin),
      .serial_out_o(sout), .serial_out_oe_o(oe), .hw_enable_i, .temp_prewarn_i,
      .over_temp_i, .supply_low_i, .over_current_i, .open_load_i, .switch_on_o,
      .open_load_en_o, .enable_o, .error_indicator_n_o(err_n), .error_indicator_n_oe_o(err_oe));
   shbc_host u_host (.mclk_i, .cs_n_o(cs_n), .sclk_o(sclk), .serial_in_o(sin),
      .serial_out_i(sout), .serial_out_oe_i(oe), .status_o(st_seen), .done_o(done));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Status reflects the command in force when the frame starts
   task automatic frame(input logic [15:0] c, input bit ch);
      logic [11:0] s;
      s = (cur[15] && hw_enable_i) ? cur[12:1] : 12'h000;
      nt.st = ot ? ALL_ONES : {supply_fail, cur[15] & hw_enable_i, 1'b0, cur[13] ? s : open_load_i,
         temp_prewarn_i};
      if (c[0]) {supply_fail, ot} = 2'b00;
      cur = c;
      nt.sw = (c[15] && hw_enable_i && !ot) ? c[12:1] : 12'h000;
      nt.en = c[15] & hw_enable_i;
      nt.ol = ~c[13];
      nt.ft = ot;
      q.push_back(nt);
      u_host.xfer(r[31:16], c, ch);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial forever begin
      @(posedge done);
      mn = q.pop_front();
      `CHK("status", mn.st, st_seen)
      repeat (10) @(posedge mclk_i);
      `CHK("switches", mn.sw, switch_on_o)
      `CHK("enable", mn.en, enable_o)
      `CHK("open load", mn.ol, open_load_en_o)
      `CHK("fault pull", mn.ft, err_oe)
      `CHK("fault level", 1'b0, err_n)
   end
   initial begin
      {mclk_i, nrst_i, hw_enable_i, temp_prewarn_i, over_temp_i, supply_low_i} = 6'b001000;
      {over_current_i, open_load_i, cur, supply_fail, ot} = {24'h000000, CMD_RESET, 2'b00};
      repeat (8) @(posedge mclk_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      for (int i = 0; i < 14; i++) begin
         r = xs();
         hw_enable_i <= (i != 6);
         supply_low_i <= (i == 8);
         over_temp_i <= (i == 11);
         temp_prewarn_i <= r[0];
         open_load_i <= r[31:20];
         repeat (4) @(posedge mclk_i);
         {supply_low_i, over_temp_i} <= 2'b00;
         repeat (8) @(posedge mclk_i);
         supply_fail |= (i == 8);
         ot |= (i == 11);
         frame({i != 5, r[14], i != 3, r[12:1], i == 9 || i == 12}, i == 2);
         $display("frame %0d", i);
      end
      repeat (20) @(posedge mclk_i);
      complete_run();
   end
   initial begin
      #400000;
      miscompares++;
      complete_run();
   end
endmodule
`default_nettype wire
